// >>> inc/fbcc_params.svh
// Offsets, field positions, reset values and counts for the compression control block
// Included by the package user modules; definitions only
`ifndef FBCC_PARAMS_SVH
`define FBCC_PARAMS_SVH
`define FBCC_ADDR_W         20
`define FBCC_BASE_OFFSET    20'h4_3200
`define FBCC_CTL_OFFSET     20'h4_3208
`define FBCC_RESET_VALUE    32'h0000_0000
`define FBCC_BASE_MASK      32'h0FFF_F000
`define FBCC_OFS_LSB        12
`define FBCC_OFS_MSB        27
`define FBCC_EN_BIT         31
`define FBCC_PLANE_MSB      30
`define FBCC_PLANE_LSB      29
`define FBCC_FENCE_EN_BIT   28
`define FBCC_LIMIT_MSB      7
`define FBCC_LIMIT_LSB      6
`define FBCC_WM_MSB         5
`define FBCC_WM_LSB         4
`define FBCC_FENCE_NUM_MSB  3
`define FBCC_FENCE_NUM_LSB  0
`define FBCC_CTL_MASK       32'hF000_00FF
`define FBCC_CNT_W          6
`endif

// >>> inc/fbcc_pkg.sv
// Types shared by the compression control block
// Assumes fbcc_params.svh is on the include path
package fbcc_pkg;
  typedef enum logic [1:0] {FBCC_PLANE_FIRST, FBCC_PLANE_SECOND, FBCC_PLANE_THIRD,
                            FBCC_PLANE_RSVD} fbcc_plane_t;
  typedef enum logic [1:0] {FBCC_LIM_1TO1, FBCC_LIM_2TO1, FBCC_LIM_4TO1,
                            FBCC_LIM_RSVD} fbcc_limit_t;
  // Settings applied to the compressor
  typedef struct packed {
    logic        enable;
    fbcc_plane_t plane;
    logic        fence_en;
    fbcc_limit_t limit;
    logic [1:0]  watermark;
    logic [3:0]  fence_num;
  } fbcc_cfg_t;
  // One compressed or raw line entry from the compressor
  typedef struct packed {
    logic        valid;
    logic [1:0]  ratio;
    logic [31:0] data;
  } fbcc_entry_t;
  // A memory write request
  typedef struct packed {
    logic        valid;
    logic [15:0] offset;
    logic [31:0] data;
  } fbcc_wr_t;
endpackage

// >>> core/fbcc_writeback.sv
// Write-back gate: collects entries and releases them in bursts at the watermark
// Assumes the memory write path accepts one word per clock
`timescale 1ns/100ps
`include "fbcc_params.svh"
module fbcc_writeback
  import fbcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        active,
  input  wire logic        flush,
  input  wire logic [1:0]  watermark,
  input  wire logic [15:0] base_offset,
  input  wire fbcc_entry_t entry,
  output fbcc_wr_t         wr
);
  localparam int DEPTH = 32;
  logic [31:0]           mem [DEPTH];
  logic [`FBCC_CNT_W-1:0] count_ff;
  logic [`FBCC_CNT_W-1:0] rd_ff;
  logic                  drain_ff;
  logic [`FBCC_CNT_W-1:0] need;
  fbcc_wr_t              nxt_wr;

  // Watermark code to entry count: 4, 8, 16, 32
  assign need = `FBCC_CNT_W'(4) << watermark;

  // Store incoming entries while collecting
  always_ff @(posedge ref_clk) begin
    if (active && entry.valid && !drain_ff) begin
      mem[count_ff[4:0]] <= entry.data;
    end
  end

  // Collect, then drain a full burst
  always_ff @(posedge ref_clk) begin
    if (!rst_b || flush || !active) begin
      count_ff <= '0;
      rd_ff    <= '0;
      drain_ff <= 1'b0;
    end else if (drain_ff) begin
      if (rd_ff == count_ff - `FBCC_CNT_W'(1)) begin
        drain_ff <= 1'b0;
        count_ff <= '0;
        rd_ff    <= '0;
      end else begin
        rd_ff <= rd_ff + `FBCC_CNT_W'(1);
      end
    end else if (entry.valid) begin
      count_ff <= count_ff + `FBCC_CNT_W'(1);
      if (count_ff + `FBCC_CNT_W'(1) >= need) begin
        drain_ff <= 1'b1;
      end
    end
  end

  // Registered write request
  always_comb begin
    nxt_wr.valid  = drain_ff && active && !flush;
    nxt_wr.offset = base_offset;
    nxt_wr.data   = mem[rd_ff[4:0]];
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wr <= '0;
    end else begin
      wr <= nxt_wr;
    end
  end
endmodule

// >>> core/fbcc_ctrl.sv
// Frame buffer compression control: two registers, vblank-timed enable, write-back gating
// Assumes a simple synchronous register port and vblank start pulse from the display pipe
`timescale 1ns/100ps
`include "fbcc_params.svh"
module fbcc_ctrl
  import fbcc_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [`FBCC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]             reg_wdata,
  output logic [31:0]                  reg_rdata,
  input  wire logic                    vblank_start,
  input  wire logic [2:0]              plane_pix_valid,
  input  wire logic [95:0]             plane_pix_data,
  output fbcc_cfg_t                    active_cfg,
  output logic                         compress_active,
  output fbcc_wr_t                     mem_wr
);
  typedef enum logic [1:0] {ST_OFF, ST_ON} fbcc_state_t;

  logic [31:0] base_ff;
  logic [31:0] ctl_ff;
  logic        en_req;
  fbcc_state_t state_ff;
  fbcc_entry_t entry_ff;
  fbcc_entry_t nxt_entry;
  logic        flush;
  logic [31:0] nxt_rdata;
  logic [31:0] pix;
  logic        pix_valid;
  logic [1:0]  plane_idx;
  logic        busy;
  logic        sel_base;
  logic        sel_ctl;
  logic        base_wr_ok;
  logic        ctl_wr_full;
  logic        ctl_wr_en_only;
  logic [2:0]  plane_hit;
  logic [31:0] plane_word [3];

  assign en_req = ctl_ff[`FBCC_EN_BIT];

  // Address decode; settings frozen from enable request until state is off
  assign busy           = state_ff == ST_ON || en_req;
  assign sel_base       = reg_addr == `FBCC_BASE_OFFSET;
  assign sel_ctl        = reg_addr == `FBCC_CTL_OFFSET;
  assign base_wr_ok     = reg_wr && sel_base && !busy;
  assign ctl_wr_full    = reg_wr && sel_ctl && !busy;
  assign ctl_wr_en_only = reg_wr && sel_ctl && busy;

  // Placement register; frozen while compression runs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      base_ff <= `FBCC_RESET_VALUE;
    end else if (base_wr_ok) begin
      base_ff <= reg_wdata & `FBCC_BASE_MASK;
    end
  end

  // Control register; while on, only the enable bit takes a write
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctl_ff <= `FBCC_RESET_VALUE;
    end else if (ctl_wr_en_only) begin
      ctl_ff[`FBCC_EN_BIT] <= reg_wdata[`FBCC_EN_BIT];
    end else if (ctl_wr_full) begin
      ctl_ff <= reg_wdata & `FBCC_CTL_MASK;
    end
  end

  // Enable taken over only at vblank start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_ff <= ST_OFF;
    end else if (vblank_start) begin
      unique case (state_ff)
        ST_OFF: if (en_req) state_ff <= ST_ON;
        ST_ON:  if (!en_req) state_ff <= ST_OFF;
        default: state_ff <= ST_OFF;
      endcase
    end
  end
  assign flush = vblank_start && state_ff == ST_ON && !en_req;

  // Applied settings snapshot at vblank start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      active_cfg <= '0;
    end else if (vblank_start) begin
      active_cfg.enable    <= en_req;
      active_cfg.plane     <= fbcc_plane_t'(ctl_ff[`FBCC_PLANE_MSB:`FBCC_PLANE_LSB]);
      active_cfg.fence_en  <= ctl_ff[`FBCC_FENCE_EN_BIT];
      active_cfg.limit     <= fbcc_limit_t'(ctl_ff[`FBCC_LIMIT_MSB:`FBCC_LIMIT_LSB]);
      active_cfg.watermark <= ctl_ff[`FBCC_WM_MSB:`FBCC_WM_LSB];
      active_cfg.fence_num <= ctl_ff[`FBCC_FENCE_NUM_MSB:`FBCC_FENCE_NUM_LSB];
    end
  end
  assign compress_active = state_ff == ST_ON;

  // Plane source select; reserved code matches no plane
  assign plane_idx = active_cfg.plane;
  for (genvar gi = 0; gi < 3; gi++) begin : g_plane
    assign plane_hit[gi]  = plane_idx == 2'(gi);
    assign plane_word[gi] = plane_hit[gi] ? plane_pix_data[gi*32 +: 32] : 32'h0000_0000;
  end
  // One-hot merge of the selected plane
  assign pix       = plane_word[0] | plane_word[1] | plane_word[2];
  assign pix_valid = |(plane_hit & plane_pix_valid);

  // Line entry tagged with the ratio; reserved limit falls back to raw storage
  always_comb begin
    nxt_entry.valid = pix_valid && compress_active;
    nxt_entry.data  = pix;
    nxt_entry.ratio = (active_cfg.limit == FBCC_LIM_RSVD) ? 2'b00
                                                          : active_cfg.limit;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      entry_ff <= '0;
    end else begin
      entry_ff <= nxt_entry;
    end
  end

  // Write-back engine
  fbcc_writeback u_wb (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .active      (compress_active),
    .flush       (flush),
    .watermark   (active_cfg.watermark),
    .base_offset (base_ff[`FBCC_OFS_MSB:`FBCC_OFS_LSB]),
    .entry       (entry_ff),
    .wr          (mem_wr)
  );

  // Read data, registered; unmapped reads return zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr == `FBCC_BASE_OFFSET) begin
      nxt_rdata = base_ff;
    end else if (reg_addr == `FBCC_CTL_OFFSET) begin
      nxt_rdata = ctl_ff;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end
  end
endmodule

// >>> verif/fbcc_ctrl_chk.sv
// Port checker for the compression control block
// Bound to fbcc_ctrl; sees only its ports
`timescale 1ns/100ps
`include "fbcc_params.svh"
module fbcc_ctrl_chk
  import fbcc_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic                    rst_b,
  input wire logic                    reg_rd,
  input wire logic [`FBCC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0]             reg_rdata,
  input wire logic                    vblank_start,
  input wire fbcc_cfg_t               active_cfg,
  input wire logic                    compress_active,
  input wire fbcc_wr_t                mem_wr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Smallest burst: four words then a gap
  sequence s_burst4;
    mem_wr.valid [*4] ##1 !mem_wr.valid;
  endsequence
  // Burst at the eight-entry watermark
  sequence s_burst8;
    mem_wr.valid [*8] ##1 !mem_wr.valid;
  endsequence
  AST_RST_ZERO: assert property (disable iff (1'b0) !rst_b |=>
    reg_rdata == 0 && active_cfg == 0 && !compress_active) else $error("reset value");
  AST_EN_AT_VBLANK: assert property (compress_active != $past(compress_active) |->
    $past(vblank_start)) else $error("enable moved off vblank");
  AST_CFG_HOLD: assert property (!$past(vblank_start) |-> $stable(active_cfg))
    else $error("settings moved off vblank");
  AST_EN_MIRROR: assert property (compress_active == active_cfg.enable)
    else $error("state and settings differ");
  AST_OFF_NO_WR: assert property (!compress_active && !$past(compress_active) |->
    !mem_wr.valid) else $error("write while off");
  AST_BURST4: assert property (disable iff (!rst_b || !compress_active)
    $rose(mem_wr.valid) && active_cfg.watermark == 2'h0 |-> s_burst4)
    else $error("burst length");
  AST_BURST8: assert property (disable iff (!rst_b || !compress_active)
    $rose(mem_wr.valid) && active_cfg.watermark == 2'h1 |-> s_burst8)
    else $error("burst length eight");
  AST_BASE_RSVD: assert property (reg_rd && reg_addr == `FBCC_BASE_OFFSET |=>
    (reg_rdata & ~`FBCC_BASE_MASK) == 0) else $error("placement reserved bits");
  AST_CTL_RSVD: assert property (reg_rd && reg_addr == `FBCC_CTL_OFFSET |=>
    reg_rdata[27:8] == 0) else $error("control reserved bits");
endmodule
bind fbcc_ctrl fbcc_ctrl_chk i_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .vblank_start(vblank_start),
  .active_cfg(active_cfg), .compress_active(compress_active), .mem_wr(mem_wr));

// >>> verif/fbcc_plane_model.sv
// Display plane model: feeds words on the one plane set by PLANE (default 1, the second plane)
// Driven by a go level from the bench; one word per clock
`timescale 1ns/100ps
module fbcc_plane_model #(
  parameter int PLANE = 1
) (
  input  wire logic   ref_clk,
  input  wire logic   go,
  output logic [2:0]  pix_valid,
  output logic [95:0] pix_data
);
  logic [31:0] cnt_ff;
  // Start idle with a known pattern
  initial begin
    cnt_ff = 32'h0000_0000;
    pix_valid = 3'h0;
    pix_data = 96'h0;
  end
  // Plane stays on while fed; idle data toggles every clock
  always @(posedge ref_clk) begin
    cnt_ff <= cnt_ff + 32'h0000_0001;
    pix_valid <= go ? 3'(1 << PLANE) : 3'h0;
    pix_data <= go ? {3{cnt_ff}} : ~pix_data;
  end
endmodule

// >>> verif/fbcc_ctrl_tb_top.sv
// Testbench for the compression control block
// Drives the register port and a plane model; checks the ports
`timescale 1ns/100ps
`include "fbcc_params.svh"
module fbcc_ctrl_tb_top;
  import fbcc_pkg::*;
  logic        ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, vblank_start = 0, go = 0;
  logic [19:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [2:0]  pix_valid;
  logic [95:0] pix_data;
  fbcc_cfg_t   active_cfg;
  logic        compress_active;
  fbcc_wr_t    mem_wr;
  int          num_errors = 0, n_tests = 0, cyc = 0, wcnt = 0;
  logic        pv = 0;
  logic [31:0] pd = 0;
  localparam logic [19:0] BA = `FBCC_BASE_OFFSET, CA = `FBCC_CTL_OFFSET;
  fbcc_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .vblank_start(vblank_start), .plane_pix_valid(pix_valid), .plane_pix_data(pix_data),
    .active_cfg(active_cfg), .compress_active(compress_active), .mem_wr(mem_wr));
  fbcc_plane_model i_plane (.ref_clk(ref_clk), .go(go), .pix_valid(pix_valid),
    .pix_data(pix_data));
  // 50 ns clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic results();
    if (num_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [19:0] a, logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    step(1);
    reg_wr = 0;
    step(1);
  endtask
  task automatic rd(logic [19:0] a, logic [31:0] exp, string nm);
    reg_addr = a;
    reg_rd = 1;
    step(1);
    reg_rd = 0;
    chk(nm, exp, reg_rdata);
    step(1);
  endtask
  task automatic vblank();
    vblank_start = 1;
    step(1);
    vblank_start = 0;
    step(1);
  endtask
  task automatic pix(int n);
    go = 1;
    step(n);
    go = 0;
    step(14);
  endtask
  // Count memory writes, check placement and word order, cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    pv <= mem_wr.valid === 1'b1;
    pd <= mem_wr.data;
    if (mem_wr.valid === 1'b1) begin
      wcnt <= wcnt + 1;
      chk("offset", 32'h0000_FFFF, 32'(mem_wr.offset));
      if (pv) chk("data", pd + 32'h0000_0001, mem_wr.data);
    end
    if (cyc == 3000) begin
      num_errors++;
      results();
    end
  end
  // Main sequence
  initial begin
    step(8);
    rst_b = 1;
    rd(BA, 0, "base_rst");
    rd(CA, 0, "ctl_rst");
    chk("cfg_rst", 0, 32'(active_cfg));
    wr(BA, 32'hFFFF_FFFF);
    rd(BA, 32'h0FFF_F000, "base");
    wr(20'h4_3204, 32'hFFFF_FFFF);
    rd(20'h4_3204, 0, "unmapped");
    wr(CA, 32'hB000_0040);
    step(3);
    chk("early", 0, 32'(compress_active));
    vblank();
    chk("on", 1, 32'(compress_active));
    chk("cfg", 32'h0000_0B40, 32'(active_cfg));
    wr(BA, 32'h0123_4000);
    rd(BA, 32'h0FFF_F000, "base_lock");
    wr(CA, 32'h8000_0000);
    rd(CA, 32'hB000_0040, "ctl_lock");
    pix(4);
    chk("burst", 4, 32'(wcnt));
    pix(3);
    chk("partial", 4, 32'(wcnt));
    wr(CA, 32'h3000_0040);
    rd(CA, 32'h3000_0040, "ctl_dis");
    vblank();
    chk("off", 0, 32'(compress_active));
    pix(4);
    chk("no_wr", 4, 32'(wcnt));
    wr(CA, 32'hB000_0050);
    vblank();
    chk("cfg2", 32'h0000_0B50, 32'(active_cfg));
    pix(8);
    chk("burst8", 12, 32'(wcnt));
    results();
  end
endmodule
